// >>> tdocb_param_bank.sv
// Purpose: indirect parameter bank for tone detection and tone generators
// Assumes: single clock, plain register port, detector powers on same clock
// Notes: row ratio threshold lives outside this bank and arrives by port
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module tdocb_param_bank
  import tdocb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [tdocb_pkg::ADDR_W-1:0] regAddr,
  input wire logic [tdocb_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [tdocb_pkg::DATA_W-1:0] regRdData,
  input wire logic [15:0] rowRatioThr,
  output tdocb_pkg::tdocb_gen_t genParams,
  input wire tdocb_pkg::tdocb_det_in_t detIn,
  output tdocb_pkg::tdocb_det_flags_t detFlags,
  output logic digitValid,
  output logic gainStep
);
  import tdocb_pkg::*;

  // ---------------------------------------------------------------
  // parameter storage
  // ---------------------------------------------------------------
  logic [15:0] regs_q [IDX_FIRST:IDX_LAST];
  logic [15:0] regs_d [IDX_FIRST:IDX_LAST];
  logic [15:0] rdData_q;
  logic [15:0] rdData_d;
  logic addrHit;

  assign addrHit = (regAddr >= IDX_FIRST) && (regAddr <= IDX_LAST);

  always_comb begin
    regs_d = regs_q;
    // all 16 bits stored, unused ones included
    if (regWr && addrHit) begin
      regs_d[regAddr] = regWrData;
    end
  end

  always_comb begin
    rdData_d = 16'h0000;
    if (regRd && addrHit) begin
      rdData_d = regs_q[regAddr];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = IDX_FIRST; i <= IDX_LAST; i++) begin
        regs_q[i] <= PARAM_RST;
      end
      rdData_q <= 16'h0000;
    end else begin
      regs_q <= regs_d;
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

  // ---------------------------------------------------------------
  // generator parameters
  // ---------------------------------------------------------------
  logic [RING_DC_W-1:0] ringDcCode;

  assign ringDcCode = regs_q[IDX_RING_DC][RING_DC_LSB +: RING_DC_W];

  always_comb begin
    // signed view of the stored words
    genParams.tone1.freq = $signed(regs_q[IDX_TONE1_FREQ]);
    genParams.tone1.amp = $signed(regs_q[IDX_TONE1_AMP]);
    genParams.tone1.phase = $signed(regs_q[IDX_TONE1_PHASE]);
    genParams.tone2.freq = $signed(regs_q[IDX_TONE2_FREQ]);
    genParams.tone2.amp = $signed(regs_q[IDX_TONE2_AMP]);
    genParams.tone2.phase = $signed(regs_q[IDX_TONE2_PHASE]);
    genParams.ring.freq = $signed(regs_q[IDX_RING_FREQ]);
    genParams.ring.amp = $signed(regs_q[IDX_RING_AMP]);
    genParams.ring.phase = $signed(regs_q[IDX_RING_PHASE]);
    genParams.ringDcCode = ringDcCode;
    // offset in tenths of a volt, code times 1.5 V
    genParams.ringDcDeciVolt = RING_DC_DV_W'(ringDcCode * RING_DC_STEP_DV);
    genParams.meter.ramp = $signed(regs_q[IDX_METER_RAMP]);
    genParams.meter.amp = $signed(regs_q[IDX_METER_AMP]);
    genParams.meter.freq = $signed(regs_q[IDX_METER_FREQ]);
  end

  // ---------------------------------------------------------------
  // detector qualification
  // ---------------------------------------------------------------
  logic rowRatioOk;
  logic colRatioOk;
  logic rowHarmOk;
  logic colHarmOk;
  logic rowPassOk;
  logic powerOk;

  tdocb_ratio_cmp #(.UNITY(UNITY_RATIO)) u_rowRatio (
    .num(detIn.rowPeak),
    .den(detIn.rowOthers),
    .thr(rowRatioThr),
    .pass(rowRatioOk)
  );

  tdocb_ratio_cmp #(.UNITY(UNITY_RATIO)) u_colRatio (
    .num(detIn.colPeak),
    .den(detIn.colOthers),
    .thr(regs_q[IDX_COL_RATIO]),
    .pass(colRatioOk)
  );

  tdocb_ratio_cmp #(.UNITY(UNITY_RATIO)) u_rowHarm (
    .num(detIn.rowPeak),
    .den(detIn.rowHarm),
    .thr(regs_q[IDX_ROW_HARM]),
    .pass(rowHarmOk)
  );

  tdocb_ratio_cmp #(.UNITY(UNITY_RATIO)) u_colHarm (
    .num(detIn.colPeak),
    .den(detIn.colHarm),
    .thr(regs_q[IDX_COL_HARM]),
    .pass(colHarmOk)
  );

  tdocb_ratio_cmp #(.UNITY(UNITY_PASS)) u_rowPass (
    .num(detIn.rowPeak),
    .den(detIn.rowBand),
    .thr(detIn.rowPassThr),
    .pass(rowPassOk)
  );

  assign powerOk = detIn.total >= regs_q[IDX_MIN_PWR];

  tdocb_det_flags_t flags_q;
  tdocb_det_flags_t flags_d;
  logic digit_q;
  logic digit_d;
  logic gain_q;
  logic gain_d;

  always_comb begin
    flags_d = flags_q;
    digit_d = 1'b0;
    if (detIn.valid) begin
      flags_d.rowRatio = rowRatioOk;
      flags_d.colRatio = colRatioOk;
      flags_d.rowHarm = rowHarmOk;
      flags_d.colHarm = colHarmOk;
      flags_d.rowPass = rowPassOk;
      flags_d.powerOk = powerOk;
      // low-power results are dropped whatever the ratios say
      digit_d = powerOk && rowRatioOk && colRatioOk && rowHarmOk && colHarmOk
                && rowPassOk;
    end
  end

  always_comb begin
    gain_d = gain_q;
    // second gain step engages above the limit level
    if (detIn.valid) begin
      gain_d = detIn.level > regs_q[IDX_LEVEL_LIMIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags_q <= '0;
      digit_q <= 1'b0;
      gain_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      digit_q <= digit_d;
      gain_q <= gain_d;
    end
  end

  assign detFlags = flags_q;
  assign digitValid = digit_q;
  assign gainStep = gain_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_write_then_read;
    regWr && addrHit ##1 regRd && !regWr && (regAddr == $past(regAddr));
  endsequence

  property p_readback;
    @(posedge clk) disable iff (!rstn)
    s_write_then_read |=> (regRdData == $past(regWrData, 2));
  endproperty
  a_readback: assert property (p_readback)
    else $error("read does not return last written word");

  property p_unmapped_read;
    @(posedge clk) disable iff (!rstn)
    (regRd && !addrHit) |=> (regRdData == 16'h0000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  property p_tone1_freq;
    @(posedge clk) disable iff (!rstn)
    (regWr && regAddr == IDX_TONE1_FREQ) |=> (genParams.tone1.freq == $past(regWrData));
  endproperty
  a_tone1_freq: assert property (p_tone1_freq)
    else $error("tone 1 frequency not updated");

  property p_tone2_phase;
    @(posedge clk) disable iff (!rstn)
    (regWr && regAddr == IDX_TONE2_PHASE) |=> (genParams.tone2.phase == $past(regWrData));
  endproperty
  a_tone2_phase: assert property (p_tone2_phase)
    else $error("tone 2 phase not updated");

  property p_ring_amp;
    @(posedge clk) disable iff (!rstn)
    (regWr && regAddr == IDX_RING_AMP) |=> (genParams.ring.amp == $past(regWrData));
  endproperty
  a_ring_amp: assert property (p_ring_amp)
    else $error("ring amplitude not updated");

  property p_meter_ramp;
    @(posedge clk) disable iff (!rstn)
    (regWr && regAddr == IDX_METER_RAMP) |=> (genParams.meter.ramp == $past(regWrData));
  endproperty
  a_meter_ramp: assert property (p_meter_ramp)
    else $error("meter ramp not updated");

  property p_ring_dc_volts;
    @(posedge clk) disable iff (!rstn)
    (regWr && regAddr == IDX_RING_DC && regWrData[5:0] == 6'h3F)
      |=> (genParams.ringDcDeciVolt == 10'd945);
  endproperty
  a_ring_dc_volts: assert property (p_ring_dc_volts)
    else $error("ring dc offset full scale not 94.5 V");

  property p_low_power_drop;
    @(posedge clk) disable iff (!rstn)
    (detIn.valid && detIn.total < regs_q[IDX_MIN_PWR]) |=> !digitValid;
  endproperty
  a_low_power_drop: assert property (p_low_power_drop)
    else $error("digit reported below minimum power");

  property p_col_ratio;
    @(posedge clk) disable iff (!rstn)
    (detIn.valid && detIn.colOthers == detIn.colPeak
      && regs_q[IDX_COL_RATIO] == UNITY_RATIO) |=> !detFlags.colRatio;
  endproperty
  a_col_ratio: assert property (p_col_ratio)
    else $error("column ratio of one passed a unity threshold");

  property p_row_harm;
    @(posedge clk) disable iff (!rstn)
    (detIn.valid && detIn.rowHarm == 16'h0000 && detIn.rowPeak != 16'h0000)
      |=> detFlags.rowHarm;
  endproperty
  a_row_harm: assert property (p_row_harm)
    else $error("row harmonic check failed with no harmonic");

  property p_gain_step;
    @(posedge clk) disable iff (!rstn)
    (detIn.valid && detIn.level > regs_q[IDX_LEVEL_LIMIT]) |=> gainStep;
  endproperty
  a_gain_step: assert property (p_gain_step)
    else $error("gain step not engaged above limit");

  property p_digit_pulse;
    @(posedge clk) disable iff (!rstn)
    !detIn.valid |=> !digitValid;
  endproperty
  a_digit_pulse: assert property (p_digit_pulse)
    else $error("digit reported without a detector sample");

  property p_rd_idle_zero;
    @(posedge clk) disable iff (!rstn)
    !regRd |=> (regRdData == 16'h0000);
  endproperty
  a_rd_idle_zero: assert property (p_rd_idle_zero)
    else $error("read data shown without a read strobe");

  property p_row_ratio_unity;
    @(posedge clk) disable iff (!rstn)
    (detIn.valid && detIn.rowOthers == detIn.rowPeak && rowRatioThr == UNITY_RATIO)
      |=> !detFlags.rowRatio;
  endproperty
  a_row_ratio_unity: assert property (p_row_ratio_unity)
    else $error("row ratio of one passed a unity threshold");

  property p_col_harm;
    @(posedge clk) disable iff (!rstn)
    (detIn.valid && detIn.colHarm == 16'h0000 && detIn.colPeak != 16'h0000)
      |=> detFlags.colHarm;
  endproperty
  a_col_harm: assert property (p_col_harm)
    else $error("column harmonic check failed with no harmonic");

  property p_row_pass_unity;
    @(posedge clk) disable iff (!rstn)
    (detIn.valid && detIn.rowBand == detIn.rowPeak && detIn.rowPassThr == UNITY_PASS)
      |=> !detFlags.rowPass;
  endproperty
  a_row_pass_unity: assert property (p_row_pass_unity)
    else $error("row pass ratio of one passed a unity threshold");

  property p_min_power_edge;
    @(posedge clk) disable iff (!rstn)
    (detIn.valid && detIn.total == regs_q[IDX_MIN_PWR]) |=> detFlags.powerOk;
  endproperty
  a_min_power_edge: assert property (p_min_power_edge)
    else $error("total power equal to minimum was rejected");

  property p_result_hold;
    @(posedge clk) disable iff (!rstn)
    !detIn.valid |=> ($stable(gainStep) && $stable(detFlags));
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("detector results changed without a sample");

  property p_meter_freq;
    @(posedge clk) disable iff (!rstn)
    (regWr && regAddr == IDX_METER_FREQ) |=> (genParams.meter.freq == $past(regWrData));
  endproperty
  a_meter_freq: assert property (p_meter_freq)
    else $error("meter frequency not updated");

endmodule

// >>> tdocb_pkg.sv
// Purpose: constants and carrier types of the tone detect / oscillator parameter bank
// Assumes: 16-bit indirect parameter words, reached by word index
// Notes: tone, ring and meter words are signed two's complement; thresholds, minimum power, level limit and ring dc code are unsigned
package tdocb_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // register indices
  localparam logic [7:0] IDX_COL_RATIO = 8'h08;
  localparam logic [7:0] IDX_ROW_HARM = 8'h09;
  localparam logic [7:0] IDX_COL_HARM = 8'h0A;
  localparam logic [7:0] IDX_MIN_PWR = 8'h0B;
  localparam logic [7:0] IDX_LEVEL_LIMIT = 8'h0C;
  localparam logic [7:0] IDX_TONE1_FREQ = 8'h0D;
  localparam logic [7:0] IDX_TONE1_AMP = 8'h0E;
  localparam logic [7:0] IDX_TONE1_PHASE = 8'h0F;
  localparam logic [7:0] IDX_TONE2_FREQ = 8'h10;
  localparam logic [7:0] IDX_TONE2_AMP = 8'h11;
  localparam logic [7:0] IDX_TONE2_PHASE = 8'h12;
  localparam logic [7:0] IDX_RING_DC = 8'h13;
  localparam logic [7:0] IDX_RING_FREQ = 8'h14;
  localparam logic [7:0] IDX_RING_AMP = 8'h15;
  localparam logic [7:0] IDX_RING_PHASE = 8'h16;
  localparam logic [7:0] IDX_METER_RAMP = 8'h17;
  localparam logic [7:0] IDX_METER_AMP = 8'h18;
  localparam logic [7:0] IDX_METER_FREQ = 8'h19;
  localparam logic [7:0] IDX_FIRST = IDX_COL_RATIO;
  localparam logic [7:0] IDX_LAST = IDX_METER_FREQ;

  // reset value of every word (content is undefined to software)
  localparam logic [15:0] PARAM_RST = 16'h0000;

  // ratio scaling codes
  localparam logic [15:0] UNITY_RATIO = 16'h07F0;
  localparam logic [15:0] UNITY_PASS = 16'h7FF0;

  // ring dc offset field and step
  localparam int RING_DC_LSB = 0;
  localparam int RING_DC_W = 6;
  localparam int RING_DC_STEP_DV = 15;
  localparam int RING_DC_DV_W = 10;

  typedef struct packed {
    logic signed [15:0] freq;
    logic signed [15:0] amp;
    logic signed [15:0] phase;
  } tdocb_osc_t;

  typedef struct packed {
    logic signed [15:0] ramp;
    logic signed [15:0] amp;
    logic signed [15:0] freq;
  } tdocb_meter_t;

  typedef struct packed {
    tdocb_osc_t tone1;
    tdocb_osc_t tone2;
    tdocb_osc_t ring;
    logic [RING_DC_W-1:0] ringDcCode;
    logic [RING_DC_DV_W-1:0] ringDcDeciVolt;
    tdocb_meter_t meter;
  } tdocb_gen_t;

  // powers from the detector filter bank, unsigned
  typedef struct packed {
    logic valid;
    logic [15:0] rowPeak;
    logic [15:0] rowOthers;
    logic [15:0] rowBand;
    logic [15:0] rowPassThr;
    logic [15:0] rowHarm;
    logic [15:0] colPeak;
    logic [15:0] colOthers;
    logic [15:0] colHarm;
    logic [15:0] total;
    logic [15:0] level;
  } tdocb_det_in_t;

  typedef struct packed {
    logic rowRatio;
    logic colRatio;
    logic rowHarm;
    logic colHarm;
    logic rowPass;
    logic powerOk;
  } tdocb_det_flags_t;

endpackage

// >>> tdocb_ratio_cmp.sv
// Purpose: power ratio check, num/den against thr/unity
// Assumes: unsigned powers and thresholds
// Notes: cross-multiplied, no divider
`timescale 1ns/1ps
module tdocb_ratio_cmp #(
  parameter logic [15:0] UNITY = tdocb_pkg::UNITY_RATIO
) (
  input wire logic [15:0] num,
  input wire logic [15:0] den,
  input wire logic [15:0] thr,
  output logic pass
);
  logic [31:0] lhs;
  logic [31:0] rhs;

  always_comb begin
    lhs = num * UNITY;
    rhs = den * thr;
    pass = lhs > rhs;
  end
endmodule

// >>> testbench.sv
// Purpose: self-checking bench for the tone detect / oscillator parameter bank
// Assumes: read data and detector results checked on the falling edge after the taking edge
// Notes: inputs change by non-blocking assignment at rising edges only
`timescale 1ns/1ps
module testbench;
  import tdocb_pkg::*;

  // ----------------------------------------
  // clock, stimulus, design
  // ----------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic [15:0] rowRatioThr = 16'h07F0;
  tdocb_gen_t genParams;
  tdocb_det_in_t detIn = '0;
  tdocb_det_flags_t detFlags;
  logic digitValid;
  logic gainStep;
  int mismatches = 0;
  int testsRun = 0;
  int cycles = 0;
  logic [15:0] mdl [256];
  logic rdDue = 1'b0;
  logic [15:0] rdExp;
  logic detDue = 1'b0;
  tdocb_det_flags_t flagExp;
  logic dvExp;
  logic gsExp;
  tdocb_det_in_t base;
  tdocb_det_in_t v;

  always #2.5 clk = ~clk;

  tdocb_param_bank i_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rowRatioThr(rowRatioThr),
    .genParams(genParams), .detIn(detIn), .detFlags(detFlags), .digitValid(digitValid),
    .gainStep(gainStep));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one bus cycle, strobes, address, write data and detector inputs assigned once
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d,
                    input tdocb_det_in_t di);
    regWr <= w;
    regRd <= r;
    regAddr <= a;
    regWrData <= d;
    detIn <= di;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    op(1'b1, 1'b0, a, d, '0);
    if (a >= IDX_FIRST && a <= IDX_LAST) begin
      mdl[a] = d;
    end
  endtask

  // unmapped words stay 0 in the model
  task automatic rd(input logic [7:0] a);
    op(1'b0, 1'b1, a, 16'h0000, '0);
    rdExp = mdl[a];
    rdDue = 1'b1;
  endtask

  function automatic logic ratio(input logic [15:0] n, input logic [15:0] dn,
                                 input logic [15:0] t, input logic [15:0] u);
    return (32'(n) * 32'(u)) > (32'(dn) * 32'(t));
  endfunction

  task automatic det(input tdocb_det_in_t di);
    op(1'b0, 1'b0, 8'h00, 16'h0000, di);
    flagExp.rowRatio = ratio(di.rowPeak, di.rowOthers, rowRatioThr, UNITY_RATIO);
    flagExp.colRatio = ratio(di.colPeak, di.colOthers, mdl[8'h08], UNITY_RATIO);
    flagExp.rowHarm = ratio(di.rowPeak, di.rowHarm, mdl[8'h09], UNITY_RATIO);
    flagExp.colHarm = ratio(di.colPeak, di.colHarm, mdl[8'h0A], UNITY_RATIO);
    flagExp.rowPass = ratio(di.rowPeak, di.rowBand, di.rowPassThr, UNITY_PASS);
    flagExp.powerOk = di.total >= mdl[8'h0B];
    dvExp = &flagExp;
    gsExp = di.level > mdl[8'h0C];
    detDue = 1'b1;
  endtask

  task automatic chk_gen(input int p);
    chk(genParams.tone1.freq, mdl[8'h0D], "tone1 freq");
    chk(genParams.tone1.amp, mdl[8'h0E], "tone1 amp");
    chk(genParams.tone1.phase, mdl[8'h0F], "tone1 phase");
    chk(genParams.tone2.freq, mdl[8'h10], "tone2 freq");
    chk(genParams.tone2.amp, mdl[8'h11], "tone2 amp");
    chk(genParams.tone2.phase, mdl[8'h12], "tone2 phase");
    chk(genParams.ring.freq, mdl[8'h14], "ring freq");
    chk(genParams.ring.amp, mdl[8'h15], "ring amp");
    chk(genParams.ring.phase, mdl[8'h16], "ring phase");
    chk(genParams.meter.ramp, mdl[8'h17], "meter ramp");
    chk(genParams.meter.amp, mdl[8'h18], "meter amp");
    chk(genParams.meter.freq, mdl[8'h19], "meter freq");
    chk(16'(genParams.ringDcCode), 16'(mdl[8'h13][5:0]), "ring dc code");
    chk(16'(genParams.ringDcDeciVolt), 16'(mdl[8'h13][5:0]) * 16'h000F, "dc volts");
    chk(16'(genParams.tone2.amp < 0), 16'(p), "signed amp");
  endtask

  // ----------------------------------------
  // result sampling and timeout
  // ----------------------------------------
  always @(negedge clk) begin
    if (rdDue) begin
      chk(regRdData, rdExp, "read data");
      rdDue = 1'b0;
    end else if (rstn) begin
      chk(regRdData, 16'h0000, "idle read data");
    end
    if (detDue) begin
      chk(16'(detFlags), 16'(flagExp), "flags");
      chk(16'(digitValid), 16'(dvExp), "digit valid");
      chk(16'(gainStep), 16'(gsExp), "gain step");
      detDue = 1'b0;
    end else if (rstn) begin
      chk(16'(digitValid), 16'h0000, "digit pulse");
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      $display("wrong value at %0t: run did not finish", $time);
      stop_test();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) begin
      mdl[i] = 16'h0000;
    end
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd(IDX_FIRST);
    rd(IDX_LAST);
    $display("test reset contents done");
    for (int p = 0; p < 2; p++) begin
      for (int i = 8; i <= 25; i++) begin
        wr(8'(i), (p == 0) ? {8'(i), 8'(~i)} : {8'(~i), 8'(i)});
      end
      wr(IDX_RING_DC, (p == 0) ? 16'hC03F : 16'h0000);
      for (int i = 19; i >= 8; i--) begin
        rd(8'(i));
      end
      for (int i = 20; i <= 25; i++) begin
        rd(8'(i));
      end
      chk_gen(p);
    end
    $display("test bank write and readback done");
    wr(8'h07, 16'hFFFF);
    wr(8'h1A, 16'hFFFF);
    rd(8'h07);
    rd(8'h1A);
    rd(IDX_FIRST);
    rd(IDX_LAST);
    $display("test unmapped access done");
    wr(IDX_COL_RATIO, UNITY_RATIO);
    wr(IDX_ROW_HARM, UNITY_RATIO);
    wr(IDX_COL_HARM, UNITY_RATIO);
    wr(IDX_MIN_PWR, 16'h0100);
    wr(IDX_LEVEL_LIMIT, 16'h0200);
    base = '{1'b1, 16'h0100, 16'h00FF, 16'h00FF, UNITY_PASS, 16'h00FF,
             16'h0100, 16'h00FF, 16'h00FF, 16'h0100, 16'h0200};
    for (int k = 0; k < 10; k++) begin
      v = base;
      case (k)
        1: v.rowOthers = 16'h0100;
        2: v.colOthers = 16'h0100;
        3: v.rowHarm = 16'h0100;
        4: v.colHarm = 16'h0100;
        5: v.rowBand = 16'h0100;
        6: v.total = 16'h00FF;
        7: v.level = 16'h0201;
        8: rowRatioThr <= 16'h0800;
        9: begin
          v.rowHarm = 16'h0000;
          v.colHarm = 16'h0000;
        end
        default: ;
      endcase
      det(v);
    end
    det(base);
    op(1'b0, 1'b0, 8'h00, 16'h0000, '0);
    op(1'b0, 1'b0, 8'h00, 16'h0000, '0);
    $display("test detector checks done");
    rstn <= 1'b0;
    op(1'b0, 1'b0, 8'h00, 16'h0000, '0);
    rstn <= 1'b1;
    for (int i = 0; i < 256; i++) begin
      mdl[i] = 16'h0000;
    end
    rd(IDX_TONE1_FREQ);
    rd(IDX_LEVEL_LIMIT);
    op(1'b0, 1'b0, 8'h00, 16'h0000, '0);
    op(1'b0, 1'b0, 8'h00, 16'h0000, '0);
    chk_gen(0);
    chk(16'(detFlags), 16'h0000, "flags after reset");
    chk(16'(gainStep), 16'h0000, "gain step after reset");
    $display("test second reset done");
    stop_test();
  end
endmodule
